// *** rtl/pll_ctrl_defs.svh ***
// What this block does
// - reference ratio 14-bit binary, 5 to 16383
// - main ratio 11-bit binary, 5 to 2047
// - swallow count 7-bit binary, 0 to 127
// - two test bits choose monitor clock
// - modulus bit picks prescaler ratio pair
// - polarity bit sets comparator drive levels
// - pin select: monitor clocks high, lock low
// - shift one bit per serial clock rise
// - correction pulses near zero error, no dead zone
// - error at upper window drops lock
// - three small-error cycles raise lock
// - sleep pin low sleeps section, high wakes
// - loading continues during sleep
// - sleeping section looks locked, comparator floats
// - sleep stops counters; oscillator off when both
// - wake-up limits first phase detector error
// - strobe high copies shift register to latch
// - two select bits choose destination latch
// - divide by modulus times main plus swallow
`ifndef PLL_CTRL_DEFS_SVH
`define PLL_CTRL_DEFS_SVH

// ----------------------------------------------------------------------
// serial word layout
// ----------------------------------------------------------------------
`define SHIFT_W        21
`define SEL_B_BIT      0
`define SEL_A_BIT      1
`define REF_LSB        2
`define REF_MSB        15
`define POL_BIT        16
`define PINSEL_BIT     17
`define MON_A_BIT      18
`define MON_B_BIT      19
`define SWAL_LSB       2
`define SWAL_MSB       8
`define MAIN_LSB       9
`define MAIN_MSB       19
`define MOD_BIT        20

// ----------------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------------
`define REF_RESET      14'h0005
`define MAIN_RESET     11'h005
`define SWAL_RESET     7'h00
`define REF_ONE        14'h0001
`define MAIN_ONE       11'h001
`define SWAL_ZERO      7'h00

// ----------------------------------------------------------------------
// timing, in oscillator periods (core_clk is the oscillator)
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS  4
`define LOCK_UP_OSC    4
`define LOCK_LO_OSC    2
`define LOCK_UP_CYC    (`LOCK_UP_OSC)
`define LOCK_LO_CYC    (`LOCK_LO_OSC)
`define LOCK_GOOD_N    3
`define OVERLAP_CYC    1
`define SYNC_W         7

`endif

// *** rtl/pll_ctrl_pkg.sv ***
package pll_ctrl_pkg;

	typedef struct packed {
		logic [13:0] ref_ratio;
		logic        polarity;
		logic        pin_select;
		logic        mon_a;
		logic        mon_b;
	} ref_cfg_s;

	typedef struct packed {
		logic [10:0] main_ratio;
		logic [6:0]  swallow;
		logic        modulus_select;
	} div_cfg_s;

	typedef enum logic [2:0] {
		ST_SLEEP = 3'b001,
		ST_WAKE  = 3'b010,
		ST_RUN   = 3'b100
	} section_state_e;

endpackage : pll_ctrl_pkg

// *** rtl/pll_serial_loader.sv ***
`timescale 1ns/1ns
`include "pll_ctrl_defs.svh"
module pll_serial_loader (
	// clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  reset,
	// synchronised serial link
	input  wire logic                  ser_rise,
	input  wire logic                  ser_data,
	input  wire logic                  load_level,
	// latches: index 0 low band, 1 high band
	output pll_ctrl_pkg::ref_cfg_s     ref_cfg [2],
	output pll_ctrl_pkg::div_cfg_s     div_cfg [2]
);
	logic [`SHIFT_W-1:0] shreg;
	wire                 sel_a = shreg[`SEL_A_BIT];
	wire                 sel_b = shreg[`SEL_B_BIT];
	wire                 hit_ref = load_level & ~sel_b;
	wire                 hit_div = load_level & sel_b;
	wire                 band = sel_a;
	pll_ctrl_pkg::ref_cfg_s word_ref;
	pll_ctrl_pkg::div_cfg_s word_div;

	assign word_ref = '{ref_ratio:  shreg[`REF_MSB:`REF_LSB],
	                    polarity:   shreg[`POL_BIT],
	                    pin_select: shreg[`PINSEL_BIT],
	                    mon_a:      shreg[`MON_A_BIT],
	                    mon_b:      shreg[`MON_B_BIT]};
	assign word_div = '{main_ratio:     shreg[`MAIN_MSB:`MAIN_LSB],
	                    swallow:        shreg[`SWAL_MSB:`SWAL_LSB],
	                    modulus_select: shreg[`MOD_BIT]};

	// shifting ignores sleep state
	always_ff @(posedge core_clk) begin
		if (reset)
			shreg <= '0;
		else if (ser_rise)
			shreg <= {shreg[`SHIFT_W-2:0], ser_data};
	end

	for (genvar i = 0; i < 2; i++) begin : g_latch
		always_ff @(posedge core_clk) begin
			if (reset) begin
				ref_cfg[i] <= '{`REF_RESET, 1'b1, 1'b0, 1'b0, 1'b0};
				div_cfg[i] <= '{`MAIN_RESET, `SWAL_RESET, 1'b1};
			end else begin
				if (hit_ref && band == 1'(i))
					ref_cfg[i] <= word_ref;
				if (hit_div && band == 1'(i))
					div_cfg[i] <= word_div;
			end
		end
	end

	property p_shift;
		@(posedge core_clk) disable iff (reset)
		ser_rise |=> shreg == {$past(shreg[`SHIFT_W-2:0]), $past(ser_data)};
	endproperty
	a_shift: assert property (p_shift)
		else $error("shift register did not take serial bit");

	property p_load_ref_low;
		@(posedge core_clk) disable iff (reset)
		load_level && !sel_a && !sel_b |=> ref_cfg[0] == $past(word_ref);
	endproperty
	a_load_ref_low: assert property (p_load_ref_low)
		else $error("low band reference latch not loaded");

	property p_load_div_high;
		@(posedge core_clk) disable iff (reset)
		load_level && sel_a && sel_b |=> div_cfg[1] == $past(word_div);
	endproperty
	a_load_div_high: assert property (p_load_div_high)
		else $error("high band divider latch not loaded");

	property p_no_load;
		@(posedge core_clk) disable iff (reset)
		!load_level |=> $stable(div_cfg[0]) && $stable(ref_cfg[1]);
	endproperty
	a_no_load: assert property (p_no_load)
		else $error("latch changed without strobe");

endmodule : pll_serial_loader

// *** rtl/pll_lock_detect.sv ***
`timescale 1ns/1ns
`include "pll_ctrl_defs.svh"
module pll_lock_detect (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic reset,
	// phase detector view
	input  wire logic sleep,
	input  wire logic err_active,
	input  wire logic cmp_done,
	// result
	output logic      locked
);
	logic [3:0] err_cnt;
	logic [1:0] good_cnt;
	wire        too_big = err_cnt >= 4'(`LOCK_UP_CYC);
	wire        within_low = err_cnt <= 4'(`LOCK_LO_CYC);

	always_ff @(posedge core_clk) begin
		if (reset || sleep)
			err_cnt <= '0;
		else if (cmp_done)
			err_cnt <= '0;
		else if (err_active && !too_big)
			err_cnt <= err_cnt + 4'h1;
	end

	always_ff @(posedge core_clk) begin
		if (reset || sleep) begin
			good_cnt <= '0;
			locked   <= 1'b1;
		end else if (too_big) begin
			good_cnt <= '0;
			locked   <= 1'b0;
		end else if (cmp_done) begin
			if (!within_low)
				good_cnt <= '0;
			else if (good_cnt == 2'(`LOCK_GOOD_N - 1))
				locked <= 1'b1;
			else
				good_cnt <= good_cnt + 2'h1;
		end
	end

	property p_unlock;
		@(posedge core_clk) disable iff (reset || sleep)
		too_big |=> !locked;
	endproperty
	a_unlock: assert property (p_unlock)
		else $error("lock held with large phase error");

	property p_lock_rise;
		@(posedge core_clk) disable iff (reset || sleep)
		$rose(locked) |-> $past(good_cnt) == 2'(`LOCK_GOOD_N - 1)
			&& $past(cmp_done) && $past(within_low);
	endproperty
	a_lock_rise: assert property (p_lock_rise)
		else $error("lock rose before three good cycles");

	c_relock: cover property (@(posedge core_clk) disable iff (reset)
		!locked ##1 locked);

endmodule : pll_lock_detect

// *** rtl/dual_pll_divider_control.sv ***
`timescale 1ns/1ns
`include "pll_ctrl_defs.svh"
module dual_pll_divider_control (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       reset,
	// serial programming pins
	input  wire logic       ser_clock,
	input  wire logic       ser_data,
	input  wire logic       load_strobe,
	// sleep pins, active low
	input  wire logic       low_band_sleep_n,
	input  wire logic       high_band_sleep_n,
	// prescaler outputs, index 0 low band, 1 high band
	input  wire logic [1:0] prescaler_out,
	// prescaler control
	output logic      [1:0] modulus_ctrl,
	output logic      [1:0] modulus_select,
	// comparator pins, four signals each
	output logic      [1:0] cmp_out,
	output logic      [1:0] cmp_oe,
	output logic      [1:0] pump_up,
	output logic      [1:0] pump_down,
	// shared lock or monitor pin
	output logic            lock_or_monitor_pin,
	output logic            lock_indicator,
	// oscillator input buffer enable
	output logic            osc_buffer_on
);
	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	logic [`SYNC_W-1:0] sync_a;
	logic [`SYNC_W-1:0] sync_b;
	logic               ser_clk_d;
	logic [1:0]         presc_d;
	wire  [`SYNC_W-1:0] pins = {prescaler_out, high_band_sleep_n,
	                            low_band_sleep_n, load_strobe, ser_data,
	                            ser_clock};

	always_ff @(posedge core_clk) begin
		if (reset) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= pins;
			sync_b <= sync_a;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ser_clk_d <= 1'b0;
			presc_d   <= '0;
		end else begin
			ser_clk_d <= sync_b[0];
			presc_d   <= sync_b[6:5];
		end
	end

	wire       ser_rise = sync_b[0] & ~ser_clk_d;
	wire       data_s = sync_b[1];
	wire       load_s = sync_b[2];
	wire [1:0] sleep = ~sync_b[4:3];
	wire [1:0] presc_rise = sync_b[6:5] & ~presc_d;

	// ------------------------------------------------------------------
	// serial loader
	// ------------------------------------------------------------------
	pll_ctrl_pkg::ref_cfg_s ref_cfg [2];
	pll_ctrl_pkg::div_cfg_s div_cfg [2];

	pll_serial_loader u_loader (
		.core_clk   (core_clk),
		.reset      (reset),
		.ser_rise   (ser_rise),
		.ser_data   (data_s),
		.load_level (load_s),
		.ref_cfg    (ref_cfg),
		.div_cfg    (div_cfg)
	);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [13:0] ref_step(input logic [13:0] cnt,
	                                         input logic [13:0] ratio);
		ref_step = (cnt <= `REF_ONE) ? ratio : cnt - `REF_ONE;
	endfunction : ref_step

	function automatic logic [10:0] main_step(input logic [10:0] cnt,
	                                          input logic [10:0] ratio);
		main_step = (cnt <= `MAIN_ONE) ? ratio : cnt - `MAIN_ONE;
	endfunction : main_step

	// ------------------------------------------------------------------
	// per section dividers and phase detector
	// ------------------------------------------------------------------
	logic [1:0] ref_clk_div;
	logic [1:0] fb_clk_div;
	logic [1:0] locked;

	for (genvar i = 0; i < 2; i++) begin : g_sec
		pll_ctrl_pkg::section_state_e state;
		pll_ctrl_pkg::section_state_e next_state;
		logic [13:0] ref_cnt;
		logic [10:0] main_cnt;
		logic [6:0]  swal_cnt;
		logic        ref_pulse;
		logic        fb_pulse;
		logic        up;
		logic        dn;
		logic        ovl;
		wire         run = state == pll_ctrl_pkg::ST_RUN;
		wire         awake = state != pll_ctrl_pkg::ST_SLEEP;
		wire         ref_tc = ref_cnt <= `REF_ONE;
		wire         main_tc = presc_rise[i] && main_cnt <= `MAIN_ONE;
		wire         both = up & dn;
		wire         cmp_done = both && ovl;
		wire         realign = state == pll_ctrl_pkg::ST_WAKE && ref_tc;

		always_comb begin
			next_state = state;
			unique case (state)
				pll_ctrl_pkg::ST_SLEEP:
					if (!sleep[i])
						next_state = pll_ctrl_pkg::ST_WAKE;
				pll_ctrl_pkg::ST_WAKE:
					if (sleep[i])
						next_state = pll_ctrl_pkg::ST_SLEEP;
					else if (ref_tc)
						next_state = pll_ctrl_pkg::ST_RUN;
				pll_ctrl_pkg::ST_RUN:
					if (sleep[i])
						next_state = pll_ctrl_pkg::ST_SLEEP;
			endcase
		end

		always_ff @(posedge core_clk) begin
			if (reset)
				state <= pll_ctrl_pkg::ST_SLEEP;
			else
				state <= next_state;
		end

		// reference divider, counts oscillator periods
		always_ff @(posedge core_clk) begin
			if (reset || !awake) begin
				ref_cnt   <= ref_cfg[i].ref_ratio;
				ref_pulse <= 1'b0;
			end else begin
				ref_cnt   <= ref_step(ref_cnt, ref_cfg[i].ref_ratio);
				ref_pulse <= ref_tc && run;
			end
		end

		// pulse swallow feedback divider
		always_ff @(posedge core_clk) begin
			if (reset || !awake || realign) begin
				main_cnt <= div_cfg[i].main_ratio;
				swal_cnt <= div_cfg[i].swallow;
				fb_pulse <= 1'b0;
			end else begin
				fb_pulse <= main_tc && run;
				if (presc_rise[i]) begin
					main_cnt <= main_step(main_cnt,
						div_cfg[i].main_ratio);
					if (main_tc)
						swal_cnt <= div_cfg[i].swallow;
					else if (swal_cnt != `SWAL_ZERO)
						swal_cnt <= swal_cnt - 7'h01;
				end
			end
		end

		// swallowing phase selects the larger modulus
		always_ff @(posedge core_clk) begin
			if (reset)
				modulus_ctrl[i] <= 1'b0;
			else
				modulus_ctrl[i] <= awake && swal_cnt != `SWAL_ZERO;
		end

		// phase frequency detector with forced overlap pulse
		always_ff @(posedge core_clk) begin
			if (reset || !run) begin
				up  <= 1'b0;
				dn  <= 1'b0;
				ovl <= 1'b0;
			end else if (cmp_done) begin
				up  <= ref_pulse;
				dn  <= fb_pulse;
				ovl <= 1'b0;
			end else begin
				up  <= up | ref_pulse;
				dn  <= dn | fb_pulse;
				ovl <= both;
			end
		end

		// monitor clocks toggle on each compare pulse
		always_ff @(posedge core_clk) begin
			if (reset) begin
				ref_clk_div[i] <= 1'b0;
				fb_clk_div[i]  <= 1'b0;
			end else begin
				ref_clk_div[i] <= ref_clk_div[i] ^ ref_pulse;
				fb_clk_div[i]  <= fb_clk_div[i] ^ fb_pulse;
			end
		end

		assign pump_up[i]        = up;
		assign pump_down[i]      = dn;
		assign cmp_oe[i]         = up ^ dn;
		assign cmp_out[i]        = ref_cfg[i].polarity ? up : dn;
		assign modulus_select[i] = div_cfg[i].modulus_select;

		pll_lock_detect u_lock (
			.core_clk   (core_clk),
			.reset      (reset),
			.sleep      (!run),
			.err_active (up ^ dn),
			.cmp_done   (cmp_done),
			.locked     (locked[i])
		);

		property p_sleep_quiet;
			@(posedge core_clk) disable iff (reset)
			state == pll_ctrl_pkg::ST_SLEEP |=> !cmp_oe[i] && locked[i];
		endproperty
		a_sleep_quiet: assert property (p_sleep_quiet)
			else $error("sleeping section drives comparator");

		property p_sleep_stop;
			@(posedge core_clk) disable iff (reset)
			state == pll_ctrl_pkg::ST_SLEEP && $past(state) ==
				pll_ctrl_pkg::ST_SLEEP |-> !ref_pulse && !fb_pulse;
		endproperty
		a_sleep_stop: assert property (p_sleep_stop)
			else $error("counters run during sleep");

		property p_wake_quiet;
			@(posedge core_clk) disable iff (reset)
			state == pll_ctrl_pkg::ST_WAKE |-> !up && !dn;
		endproperty
		a_wake_quiet: assert property (p_wake_quiet)
			else $error("phase error output during wake-up");

		property p_polarity;
			@(posedge core_clk) disable iff (reset)
			cmp_oe[i] |-> cmp_out[i] == (ref_cfg[i].polarity ~^ up);
		endproperty
		a_polarity: assert property (p_polarity)
			else $error("comparator level wrong for polarity");

		property p_overlap;
			@(posedge core_clk) disable iff (reset || !run)
			$rose(up & dn) |-> (pump_up[i] && pump_down[i])[*2];
		endproperty
		a_overlap: assert property (p_overlap)
			else $error("correction pulse overlap too short");

		property p_ref_period;
			@(posedge core_clk) disable iff (reset || !run)
			ref_pulse && ref_cfg[i].ref_ratio == `REF_RESET
				&& $stable(ref_cfg[i]) |-> ##5 ref_pulse;
		endproperty
		a_ref_period: assert property (p_ref_period)
			else $error("reference divider period wrong");

		c_lock_run: cover property (@(posedge core_clk) disable iff (reset)
			run && $rose(locked[i]));
		c_wake: cover property (@(posedge core_clk) disable iff (reset)
			state == pll_ctrl_pkg::ST_WAKE ##1 run);
	end

	// ------------------------------------------------------------------
	// shared output pin and oscillator buffer
	// ------------------------------------------------------------------
	wire mon_a = ref_cfg[0].mon_a;
	wire mon_b = ref_cfg[0].mon_b;
	wire [3:0] mon_set = {fb_clk_div[1], fb_clk_div[0],
	                      ref_clk_div[1], ref_clk_div[0]};
	wire monitor = mon_set[{mon_b, mon_a}];
	wire both_locked = &locked;
	wire next_pin = ref_cfg[0].pin_select ? monitor : both_locked;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			lock_or_monitor_pin <= 1'b1;
			lock_indicator      <= 1'b1;
			osc_buffer_on       <= 1'b0;
		end else begin
			lock_or_monitor_pin <= next_pin;
			lock_indicator      <= both_locked;
			osc_buffer_on       <= ~&sleep;
		end
	end

	property p_pin_mux;
		@(posedge core_clk) disable iff (reset)
		!ref_cfg[0].pin_select |=> lock_or_monitor_pin == $past(&locked);
	endproperty
	a_pin_mux: assert property (p_pin_mux)
		else $error("shared pin shows wrong source");

	property p_monitor_sel;
		@(posedge core_clk) disable iff (reset)
		ref_cfg[0].pin_select && mon_a && !mon_b
			|=> lock_or_monitor_pin == $past(ref_clk_div[1]);
	endproperty
	a_monitor_sel: assert property (p_monitor_sel)
		else $error("monitor select does not give high band ref");

	property p_osc_off;
		@(posedge core_clk) disable iff (reset)
		##1 !osc_buffer_on |-> $past(sleep) == 2'h3;
	endproperty
	a_osc_off: assert property (p_osc_off)
		else $error("oscillator off with a section awake");

	c_both_sleep: cover property (@(posedge core_clk) disable iff (reset)
		osc_buffer_on ##1 !osc_buffer_on);

endmodule : dual_pll_divider_control

// *** dv/pll_host_model.sv ***
`timescale 1ns/1ns
module pll_host_model (
	// clock
	input  wire logic core_clk,
	// serial programming pins
	output logic      ser_clock,
	output logic      ser_data,
	output logic      load_strobe,
	// sleep pins, active low
	output logic      low_band_sleep_n,
	output logic      high_band_sleep_n
);
	initial begin
		ser_clock = 1'b0;
		ser_data = 1'b0;
		load_strobe = 1'b0;
		low_band_sleep_n = 1'b0;
		high_band_sleep_n = 1'b0;
	end

	// ------------------------------------------------------------------
	// serial word, msb first so the select bits land last
	// ------------------------------------------------------------------
	task automatic send_word(input logic [20:0] word);
		for (int i = 20; i >= 0; i--) begin
			@(posedge core_clk) ser_data <= word[i];
			repeat (4) @(posedge core_clk);
			ser_clock <= 1'b1;
			repeat (4) @(posedge core_clk);
			ser_clock <= 1'b0;
			// data no longer held: show the inverse
			ser_data <= ~word[i];
		end
		repeat (5) @(posedge core_clk);
		load_strobe <= 1'b1;
		repeat (4) @(posedge core_clk);
		load_strobe <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask : send_word

	task automatic set_sleep(input logic [1:0] awake);
		@(posedge core_clk);
		high_band_sleep_n <= awake[1];
		low_band_sleep_n <= awake[0];
	endtask : set_sleep
endmodule : pll_host_model

// *** dv/dual_pll_divider_control_test.sv ***
`timescale 1ns/1ns
`include "pll_ctrl_defs.svh"
`define CHK(g, e) begin \
	compares++; \
	if ((g) !== (e)) begin \
		err_count++; \
		$display("wrong value at %0t: %0h vs %0h", $time, (g), (e)); \
	end \
end
module dual_pll_divider_control_test;
	logic       core_clk;
	logic       reset;
	logic       ser_clock;
	logic       ser_data;
	logic       load_strobe;
	logic       low_band_sleep_n;
	logic       high_band_sleep_n;
	logic [1:0] prescaler_out;
	logic [1:0] modulus_ctrl;
	logic [1:0] modulus_select;
	logic [1:0] cmp_out;
	logic [1:0] cmp_oe;
	logic [1:0] pump_up;
	logic [1:0] pump_down;
	logic       lock_or_monitor_pin;
	logic       lock_indicator;
	logic       osc_buffer_on;
	logic [2:0] psc_cnt [2];
	logic [1:0] exp_mod;
	logic       pol_now;
	logic       seen_unlock;
	logic       last_pin;
	int         err_count;
	int         compares;
	int         toggles;
	int         oe_hits;
	int         mod_hits;
	int         seed;
	int         exp_tog [4];

	pll_host_model host (
		.core_clk          (core_clk),
		.ser_clock         (ser_clock),
		.ser_data          (ser_data),
		.load_strobe       (load_strobe),
		.low_band_sleep_n  (low_band_sleep_n),
		.high_band_sleep_n (high_band_sleep_n)
	);

	dual_pll_divider_control dut (
		.core_clk            (core_clk),
		.reset               (reset),
		.ser_clock           (ser_clock),
		.ser_data            (ser_data),
		.load_strobe         (load_strobe),
		.low_band_sleep_n    (low_band_sleep_n),
		.high_band_sleep_n   (high_band_sleep_n),
		.prescaler_out       (prescaler_out),
		.modulus_ctrl        (modulus_ctrl),
		.modulus_select      (modulus_select),
		.cmp_out             (cmp_out),
		.cmp_oe              (cmp_oe),
		.pump_up             (pump_up),
		.pump_down           (pump_down),
		.lock_or_monitor_pin (lock_or_monitor_pin),
		.lock_indicator      (lock_indicator),
		.osc_buffer_on       (osc_buffer_on)
	);

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// ------------------------------------------------------------------
	// toy prescaler: period 4, or 5 while swallowing
	// ------------------------------------------------------------------
	always @(posedge core_clk) begin
		for (int i = 0; i < 2; i++) begin
			if (reset) begin
				psc_cnt[i] <= 3'(i);
				prescaler_out[i] <= 1'b0;
			end else begin
				if (psc_cnt[i] >= (modulus_ctrl[i] ? 3'h4 : 3'h3))
					psc_cnt[i] <= 3'h0;
				else
					psc_cnt[i] <= psc_cnt[i] + 3'h1;
				prescaler_out[i] <= (psc_cnt[i] < 3'h2);
			end
		end
	end

	// ------------------------------------------------------------------
	// word builders
	// ------------------------------------------------------------------
	function automatic logic [20:0] ref_word(logic band, logic [13:0] r,
		logic pol, logic pin, logic ma, logic mb);
		logic [20:0] w;
		w = 21'h000000;
		w[`REF_MSB:`REF_LSB] = r;
		w[`POL_BIT] = pol;
		w[`PINSEL_BIT] = pin;
		w[`MON_A_BIT] = ma;
		w[`MON_B_BIT] = mb;
		w[`SEL_A_BIT] = band;
		return w;
	endfunction : ref_word

	function automatic logic [20:0] div_word(logic band, logic [10:0] n,
		logic [6:0] a, logic m);
		logic [20:0] w;
		w = 21'h000000;
		w[`MAIN_MSB:`MAIN_LSB] = n;
		w[`SWAL_MSB:`SWAL_LSB] = a;
		w[`MOD_BIT] = m;
		w[`SEL_A_BIT] = band;
		w[`SEL_B_BIT] = 1'b1;
		return w;
	endfunction : div_word

	// watch low band: pin toggles, comparator level, lock drops
	task automatic watch(input int n);
		toggles = 0;
		oe_hits = 0;
		mod_hits = 0;
		for (int i = 0; i < n; i++) begin
			@(negedge core_clk);
			if (lock_or_monitor_pin !== last_pin)
				toggles++;
			last_pin = lock_or_monitor_pin;
			if (lock_indicator === 1'b0)
				seen_unlock = 1'b1;
			if (modulus_ctrl[0] === 1'b1)
				mod_hits++;
			if (pump_up[0] === pump_down[0])
				`CHK(cmp_oe[0], 1'b0)
			if (cmp_oe[0] === 1'b1) begin
				oe_hits++;
				`CHK(cmp_out[0], pol_now ~^ pump_up[0])
			end
		end
	endtask : watch

	task automatic stop_test;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test

	initial begin
		repeat (40000) @(posedge core_clk);
		err_count++;
		stop_test;
	end

	initial begin
		logic [10:0] n;
		logic [6:0]  a;
		logic [1:0]  wake_seq [4];
		seed = 72684;
		err_count = 0;
		compares = 0;
		reset = 1'b1;
		seen_unlock = 1'b0;
		exp_mod = 2'b11;
		exp_tog = '{20, 0, 5, 0};
		wake_seq = '{2'b01, 2'b10, 2'b11, 2'b00};
		repeat (6) @(posedge core_clk);
		reset <= 1'b0;
		repeat (2) @(negedge core_clk);
		`CHK(modulus_select, 2'b11)
		`CHK(cmp_oe, 2'b00)
		`CHK(lock_indicator, 1'b1)
		`CHK(lock_or_monitor_pin, 1'b1)
		`CHK(osc_buffer_on, 1'b0)
		`CHK(modulus_ctrl, 2'b00)
		// divider loads while both sections sleep
		for (int k = 0; k < 4; k++) begin
			n = 11'(5 + ({$random(seed)} % 2043));
			a = 7'({$random(seed)} % 128);
			if (k == 3) begin
				n = 11'h7FF;
				a = 7'h7F;
			end
			if (a >= n)
				a = 7'(n - 11'h001);
			exp_mod[k[0]] = k[1];
			host.send_word(div_word(k[0], n, a, k[1]));
			@(negedge core_clk);
			`CHK(modulus_select, exp_mod)
		end
		repeat (250) @(posedge core_clk);
		for (int k = 0; k < 4; k++) begin
			host.set_sleep(wake_seq[k]);
			repeat (6) @(negedge core_clk);
			`CHK(osc_buffer_on, wake_seq[k] != 2'b00)
		end
		`CHK(cmp_oe, 2'b00)
		`CHK(lock_indicator, 1'b1)
		host.send_word(ref_word(1'b0, 14'h0005, 1'b1, 1'b0, 1'b0, 1'b0));
		host.send_word(div_word(1'b0, 11'h005, 7'h00, 1'b1));
		host.set_sleep(2'b01);
		for (int i = 0; i < 8; i++) begin
			@(negedge core_clk);
			`CHK(cmp_oe[0], 1'b0)
		end
		for (int p = 0; p < 2; p++) begin
			pol_now = p[0];
			host.send_word(ref_word(1'b0, 14'h0005, p[0], 1'b0, 1'b0, 1'b0));
			watch(200);
			`CHK(oe_hits > 0, 1'b1)
			`CHK(mod_hits, 0)
		end
		`CHK(seen_unlock, 1'b1)
		for (int k = 0; k < 4; k++) begin
			host.send_word(ref_word(1'b0, 14'h0005, pol_now, 1'b1, k[0],
				k[1]));
			last_pin = lock_or_monitor_pin;
			watch(100);
			`CHK((toggles - exp_tog[k]) inside {[-1:1]}, 1'b1)
		end
		// swallow of two: larger modulus for part of each period
		host.send_word(div_word(1'b0, 11'h005, 7'h02, 1'b1));
		watch(100);
		`CHK(mod_hits inside {[20:70]}, 1'b1)
		stop_test;
	end
endmodule : dual_pll_divider_control_test
